// ### hdl/sgpm_top.sv
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sgpm_consts.svh"
module sgpm_top
  import sgpm_pkg::*;
#(
  parameter int TICK_CYC = `SG_SEC_NS / `SG_CLK_PERIOD_NS,
  parameter int FADE_LEN = 16,
  parameter int MEM_NUM = 6
)(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire sgpm_sup_t supply,
  input wire logic [2:0] keptMem,
  input wire logic indDone,
  output logic audioEn,
  output logic [7:0] fadeLvl,
  output logic [4:0] gainCut,
  output logic [2:0] curMem,
  output logic toneEn,
  output logic indReq,
  output logic lowBatReq,
  output logic commitReq
);
  // A literal cannot be part-selected, so the fingerprint lives in a constant.
  localparam logic [127:0] FP_WORDS = `SG_FP_VAL;
  sgpm_st_t st;
  sgpm_st_t nx;
  logic tick;
  logic wrGo;
  logic [3:0] wrIdx;
  logic [3:0] rdIdx;
  logic [15:0] wMask;
  logic btnRise;

  // Word index of a register, or all ones when out of the map.
  function automatic logic [3:0] regIdx(input logic [31:0] a);
    if (a[31:5] != 27'h0 || a[1:0] != 2'h0)
    begin
      return 4'hF;
    end
    return {1'b0, a[4:2]};
  endfunction

  // Next memory after a button press, wrapping back to memory A.
  function automatic logic [2:0] nextMem(input logic [2:0] m);
    if (32'(m) >= MEM_NUM - 1)
    begin
      return 3'h0;
    end
    return m + 3'h1;
  endfunction

  // Handshake terms; address and data are taken together.
  assign awready = awvalid && wvalid && !st.bvalid;
  assign wready = awready;
  assign wrGo = awready;
  assign arready = !st.rvalid;
  assign wrIdx = regIdx(awaddr);
  assign rdIdx = regIdx(araddr);
  assign wMask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
  assign tick = st.pre == 27'(TICK_CYC - 1);
  assign btnRise = st.flt[`SG_IN_BTN] && !st.btnOld;

  // Outputs from the state record.
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign fadeLvl = st.fade;
  assign gainCut = st.gain;
  assign curMem = st.mem;
  assign toneEn = st.toneEn;
  assign indReq = st.indReq;
  assign lowBatReq = st.lowReq;
  assign commitReq = st.commit;
  assign audioEn = st.fade != 8'h0 && !st.supMute && !st.avgMute;

  // Next-state logic for the whole block.
  always_comb
  begin
    nx = st;
    nx.indReq = 1'b0;
    nx.lowReq = 1'b0;
    nx.commit = 1'b0;
    // Three-stage synchroniser; a level counts once stages two and three agree.
    nx.s1 = supply;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    nx.flt = (st.s2 & st.s3) | (st.flt & (st.s2 ^ st.s3));
    nx.btnOld = st.flt[`SG_IN_BTN];
    nx.pre = tick ? 27'h0 : st.pre + 27'h1;
    // Register writes; values are volatile and lost on reset.
    if (st.bvalid && bready)
    begin
      nx.bvalid = 1'b0;
    end
    if (wrGo)
    begin
      nx.bvalid = 1'b1;
      nx.bresp = 2'h0;
      unique case (wrIdx)
        `SG_REG_CTRL:
        begin
          nx.mode = sgpm_mode_t'((wdata[1:0] & wMask[1:0]) | (st.mode & ~wMask[1:0]));
          if (wstrb[0])
          begin
            nx.lowEn = wdata[2];
            nx.indEn = wdata[3];
            nx.toneCfg = wdata[4];
            nx.prog = wdata[5];
          end
          if (wstrb[1])
          begin
            nx.porDly = wdata[11:8] > `SG_POR_MAX_S ? `SG_POR_MAX_S : wdata[11:8];
          end
        end
        `SG_REG_MEM:
        begin
          if (wstrb[0])
          begin
            nx.memTgt = 32'(wdata[2:0]) < MEM_NUM ? wdata[2:0] : 3'h0;
            nx.memPend = 1'b1;
          end
        end
        `SG_REG_COMMIT:
          nx.commit = wstrb[0] && wdata[0];
        default:
          nx.bresp = wrIdx == 4'hF ? 2'h2 : 2'h0;
      endcase
    end
    // Register reads.
    if (st.rvalid && rready)
    begin
      nx.rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      nx.rvalid = 1'b1;
      nx.rresp = 2'h0;
      nx.rdata = 32'h0;
      unique case (rdIdx)
        `SG_REG_CTRL:
          nx.rdata = {20'h0, st.porDly, 2'h0, st.prog, st.toneCfg, st.indEn,
            st.lowEn, st.mode};
        `SG_REG_MEM:
          nx.rdata = {29'h0, st.mem};
        `SG_REG_COMMIT:
          nx.rdata = 32'h0;
        `SG_REG_STAT:
          nx.rdata = {11'h0, st.toneEn, st.fade, st.avgCuts, st.instCuts,
            st.avgMute, st.supMute, st.fsm};
        4'hF:
          nx.rresp = 2'h2;
        default:
          nx.rdata = FP_WORDS[32 * (rdIdx - `SG_REG_FP0) +: 32];
      endcase
    end
    // Button presses request the next memory outside the power-on delay.
    if (btnRise && st.fsm != ST_POR && st.fsm != ST_INIT)
    begin
      nx.memTgt = nextMem(st.mem);
      nx.memPend = 1'b1;
    end
    // Fader sequencer.
    unique case (st.fsm)
      ST_INIT:
      begin
        nx.fade = 8'h0;
        if (st.pre == 27'h4)
        begin
          nx.mem = st.flt[`SG_IN_COLD] ? 3'h0 : keptMem;
          nx.memTgt = nx.mem;
          nx.memPend = 1'b0;
          nx.fsm = ST_POR;
        end
      end
      ST_POR:
      begin
        nx.memPend = 1'b0;
        if (tick)
        begin
          nx.porSec = st.porSec + 4'h1;
        end
        if (st.porSec >= st.porDly)
        begin
          nx.fsm = ST_FIN;
        end
      end
      ST_RUN, ST_FIN:
      begin
        if (st.prog || st.memPend || st.toneCfg != st.toneEn)
        begin
          nx.fsm = ST_FOUT;
        end
        else if (st.fsm == ST_FIN)
        begin
          nx.fade = st.fade + 8'h1;
          if (32'(st.fade) >= FADE_LEN - 1)
          begin
            nx.fsm = ST_RUN;
          end
        end
      end
      ST_FOUT:
      begin
        if (st.fade != 8'h0)
        begin
          nx.fade = st.fade - 8'h1;
        end
        else if (st.memPend && st.indEn)
        begin
          nx.indReq = 1'b1;
          nx.fsm = ST_IND;
        end
        else
        begin
          nx.fsm = ST_SW;
        end
      end
      ST_IND:
        if (indDone)
        begin
          nx.fsm = ST_SW;
        end
      ST_SW:
      begin
        if (st.memPend)
        begin
          nx.mem = st.memTgt;
        end
        nx.memPend = 1'b0;
        nx.toneEn = st.toneCfg;
        if (!st.prog)
        begin
          nx.fsm = ST_FIN;
        end
      end
      default:
        nx.fsm = ST_INIT;
    endcase
    // Shallow and deep supply mute.
    if (st.mode != MD_ADV)
    begin
      if (st.flt[`SG_IN_LO095])
      begin
        nx.supMute = 1'b1;
      end
      if (st.mode == MD_DEEP && st.supMute && st.flt[`SG_IN_LO060])
      begin
        nx.hardSeen = 1'b1;
        nx.mem = 3'h0;
        nx.memPend = 1'b0;
      end
      if (st.flt[`SG_IN_HI110] && (st.mode != MD_DEEP || st.hardSeen))
      begin
        nx.supMute = 1'b0;
        nx.hardSeen = 1'b0;
      end
    end
    else
    begin
      nx.supMute = 1'b0;
      // Instantaneous cuts, own timer.
      if (tick)
      begin
        nx.instSec = st.instSec + 5'h1;
      end
      if (!st.flt[`SG_IN_HI110])
      begin
        nx.all110 = 1'b0;
      end
      if (!st.flt[`SG_IN_HI100])
      begin
        nx.all100 = 1'b0;
      end
      if (tick && st.instSec == `SG_STAB_S - 5'h1)
      begin
        nx.instSec = 5'h0;
        nx.all110 = 1'b1;
        nx.all100 = 1'b1;
        nx.stab = 1'b0;
        if (!st.stab && st.all110)
        begin
          nx.instCuts = 2'h0;
        end
        else if (!st.stab && st.all100 && st.instCuts == `SG_INST_MAX)
        begin
          nx.instCuts = 2'h1;
        end
      end
      if (!st.stab && st.flt[`SG_IN_LO095] && !st.flt[`SG_IN_ALO095]
          && st.instCuts < `SG_INST_MAX)
      begin
        nx.instCuts = st.instCuts + 2'h1;
        nx.stab = 1'b1;
        nx.instSec = 5'h0;
      end
      // Average cuts, own timer.
      if (st.flt[`SG_IN_ALO095] || st.flt[`SG_IN_AHI110])
      begin
        if (tick)
        begin
          nx.avgSec = st.avgSec + 4'h1;
        end
      end
      else
      begin
        nx.avgSec = 4'h0;
      end
      if (st.flt[`SG_IN_AHI110])
      begin
        nx.avgMute = 1'b0;
      end
      if (tick && st.avgSec == `SG_AVG_STEP_S - 4'h1)
      begin
        nx.avgSec = 4'h0;
        if (st.flt[`SG_IN_ALO095] && st.avgCuts < `SG_AVG_MAX)
        begin
          nx.avgCuts = st.avgCuts + 5'h1;
          nx.avgMute = nx.avgCuts == `SG_AVG_MAX;
        end
        else if (st.flt[`SG_IN_AHI110] && st.avgCuts != 5'h0)
        begin
          nx.avgCuts = st.avgCuts - 5'h1;
        end
      end
    end
    nx.gain = 5'(3 * nx.instCuts) + nx.avgCuts;
    // Low battery indication, first at once, then every five minutes.
    if (st.lowEn && st.flt[`SG_IN_LOWBAT] && !st.lowSeen)
    begin
      nx.lowSeen = 1'b1;
      nx.lowReq = 1'b1;
      nx.lowSec = 9'h0;
    end
    else if (st.lowSeen && tick)
    begin
      nx.lowSec = st.lowSec + 9'h1;
      if (st.lowSec == `SG_LOWBAT_S - 9'h1)
      begin
        nx.lowSec = 9'h0;
        nx.lowReq = st.lowEn;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st <= '0;
      st.porDly <= `SG_POR_DLY_RST;
    end
    else
    begin
      st <= nx;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_por_mute;
    st.fsm == ST_POR |-> !audioEn;
  endproperty
  a_por_mute: assert property (p_por_mute) else $error("Audio on in delay.");
  property p_por_btn;
    st.fsm == ST_POR ##1 st.fsm == ST_POR |-> !st.memPend;
  endproperty
  a_por_btn: assert property (p_por_btn) else $error("Press taken in delay.");
  property p_mem_quiet;
    !$stable(curMem) && $past(st.fsm) != ST_INIT |-> $past(!audioEn);
  endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("Memory switched loud.");
  property p_shallow;
    st.mode == MD_SHALLOW && st.flt[`SG_IN_LO095] |=> !audioEn ##1 !audioEn;
  endproperty
  a_shallow: assert property (p_shallow) else $error("No low mute.");
  property p_inst_step;
    st.instCuts > $past(st.instCuts) |-> $past(!st.stab) && st.stab && st.instCuts <= 2'h2;
  endproperty
  a_inst_step: assert property (p_inst_step) else $error("Bad dip cut.");
  property p_avg_mute;
    $rose(st.avgMute) |-> st.avgCuts == 5'h12;
  endproperty
  a_avg_mute: assert property (p_avg_mute) else $error("Early avg mute.");
  property p_gain;
    !$stable(st.gain) |-> !$stable(st.instCuts) || !$stable(st.avgCuts);
  endproperty
  a_gain: assert property (p_gain) else $error("Gain moved alone.");
  property p_fp;
    arvalid && arready && rdIdx == 4'h4 |=> rvalid && rdata == FP_WORDS[31:0];
  endproperty
  a_fp: assert property (p_fp) else $error("Fingerprint changed.");
  property p_commit;
    wrGo && wrIdx == 4'h2 && wstrb[0] && wdata[0] |=> commitReq ##1 !commitReq;
  endproperty
  a_commit: assert property (p_commit) else $error("Commit lost.");
  c_mem: cover property (st.fsm == ST_SW && st.memPend);
  c_cut: cover property (st.instCuts == 2'h2);
  c_low: cover property (lowBatReq);
endmodule
`default_nettype wire

// ### hdl/sgpm_consts.svh
`ifndef SGPM_CONSTS_SVH
`define SGPM_CONSTS_SVH
`define SG_CLK_PERIOD_NS 10
`define SG_SEC_NS 1000000000
`define SG_POR_MAX_S 4'hB
`define SG_POR_DLY_RST 4'h2
`define SG_STAB_S 5'h1E
`define SG_AVG_STEP_S 4'hA
`define SG_AVG_MAX 5'h12
`define SG_INST_MAX 2'h2
`define SG_LOWBAT_MIN 5
`define SG_LOWBAT_S 9'(`SG_LOWBAT_MIN * 60)
`define SG_REG_CTRL 4'h0
`define SG_REG_MEM 4'h1
`define SG_REG_COMMIT 4'h2
`define SG_REG_STAT 4'h3
`define SG_REG_FP0 4'h4
// The fingerprint value is arbitrary; it only has to be fixed and readable.
`define SG_FP_VAL 128'h0123456789ABCDEF0F1E2D3C4B5A6978
`define SG_IN_LO095 0
`define SG_IN_HI110 1
`define SG_IN_HI100 2
`define SG_IN_LO060 3
`define SG_IN_ALO095 4
`define SG_IN_AHI110 5
`define SG_IN_LOWBAT 6
`define SG_IN_BTN 7
`define SG_IN_COLD 8
`endif

// ### hdl/sgpm_pkg.sv
package sgpm_pkg;
  typedef enum logic [2:0] {
    ST_INIT = 3'h0, ST_POR = 3'h1, ST_RUN = 3'h2, ST_FOUT = 3'h3,
    ST_IND = 3'h4, ST_SW = 3'h5, ST_FIN = 3'h6
  } sgpm_fsm_t;
  typedef enum logic [1:0] {
    MD_SHALLOW = 2'h0, MD_DEEP = 2'h1, MD_ADV = 2'h2
  } sgpm_mode_t;
  // Raw comparator and pin levels, one bit per flag.
  typedef struct packed {
    logic coldStart;
    logic button;
    logic lowBat;
    logic avgHi110;
    logic avgLo095;
    logic instLo060;
    logic instHi100;
    logic instHi110;
    logic instLo095;
  } sgpm_sup_t;
  typedef struct packed {
    sgpm_fsm_t fsm;
    logic [8:0] s1, s2, s3, flt;
    logic btnOld;
    logic [26:0] pre;
    logic [3:0] porSec;
    logic [7:0] fade;
    logic [2:0] mem, memTgt;
    logic memPend, toneEn, indReq;
    logic supMute, hardSeen, avgMute;
    logic [1:0] instCuts;
    logic stab, all110, all100;
    logic [4:0] instSec;
    logic [4:0] avgCuts;
    logic [3:0] avgSec;
    logic lowSeen, lowReq;
    logic [8:0] lowSec;
    logic [4:0] gain;
    sgpm_mode_t mode;
    logic lowEn, indEn, toneCfg, prog, commit;
    logic [3:0] porDly;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } sgpm_st_t;
endpackage

// ### tb/sgpm_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module sgpm_far_model
  import sgpm_pkg::*;
(
  input wire logic clk_sys,
  input wire sgpm_sup_t want,
  input wire logic [3:0] lag,
  input wire logic indReq,
  output var sgpm_sup_t supply,
  output logic indDone
);
  logic [3:0] cnt = 4'h0;

  // The comparators follow the battery level one clock late.
  always_ff @(posedge clk_sys)
  begin
    supply <= want;
  end

  // The indicator player ends each request after a varying delay.
  always_ff @(posedge clk_sys)
  begin
    if (indReq)
      cnt <= lag;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end

  assign indDone = (cnt == 4'h1);
endmodule
`default_nettype wire

// ### tb/sgpm_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sgpm_consts.svh"
module sgpm_top_tb_top
  import sgpm_pkg::*;
  ;
  localparam sgpm_sup_t OK = 9'h026;
  localparam sgpm_sup_t DIP = 9'h021;
  localparam sgpm_sup_t MID = 9'h024;
  localparam logic [127:0] FP_WORDS = `SG_FP_VAL;
  logic clk_sys;
  logic srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0] lag = 4'h3;
  logic [2:0] keptMem = 3'h0, curMem, tgt;
  sgpm_sup_t want = OK, supply;
  logic awready, wready, bvalid, arready, rvalid, audioEn, toneEn, indReq, lowBatReq;
  logic commitReq, indDone;
  logic [1:0] bresp, rresp;
  logic [7:0] fadeLvl, minFade = 8'hFF;
  logic [4:0] gainCut;
  logic [33:0] expQ[$], expV;
  int badCount = 0, checks = 0, cyc = 0, lowCnt = 0, comCnt = 0;

  sgpm_top #(.TICK_CYC(10), .FADE_LEN(16), .MEM_NUM(6)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .supply(supply),
    .keptMem(keptMem), .indDone(indDone), .audioEn(audioEn), .fadeLvl(fadeLvl),
    .gainCut(gainCut), .curMem(curMem), .toneEn(toneEn), .indReq(indReq),
    .lowBatReq(lowBatReq), .commitReq(commitReq));

  sgpm_far_model u_far (.clk_sys(clk_sys), .want(want), .lag(lag), .indReq(indReq),
    .supply(supply), .indDone(indDone));

  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Register write; the response code is checked after the address and data handshake.
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk_sys); while (awready !== 1'b1);
    @(posedge clk_sys);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk_sys); while (bvalid !== 1'b1);
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask

  // Register read; the expected response and data go to the queue.
  task automatic axr(input logic [31:0] a, input logic [33:0] e);
    expQ.push_back(e);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk_sys); while (arready !== 1'b1);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    do @(negedge clk_sys); while (rvalid !== 1'b1);
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask

  task automatic setw(input sgpm_sup_t v, input int n);
    @(posedge clk_sys);
    want <= v;
    repeat (n) @(negedge clk_sys);
  endtask

  // Watches the outputs, pairs read data with the oldest note, and cuts hangs.
  always @(negedge clk_sys)
  begin
    cyc++;
    if (rvalid === 1'b1 && rready === 1'b1 && expQ.size() > 0)
    begin
      expV = expQ.pop_front();
      cmp("rresp", {30'h0, expV[33:32]}, {30'h0, rresp});
      cmp("rdata", expV[31:0], rdata);
    end
    if (lowBatReq === 1'b1)
      lowCnt++;
    if (commitReq === 1'b1)
      comCnt++;
    if (fadeLvl < minFade)
      minFade = fadeLvl;
    if (cyc > 20000)
    begin
      badCount++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(70));
    keptMem = 3'($urandom_range(5, 1));
    tgt = keptMem % 3'h5 + 3'h1;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (11) @(negedge clk_sys);
    setw(9'h0A6, 2);
    setw(OK, 6);
    cmp("audioEn", 0, audioEn);
    for (int i = 0; i < 90 && fadeLvl !== 8'h10; i++) @(negedge clk_sys);
    cmp("audioEn", 1, audioEn);
    cmp("curMem", keptMem, curMem);
    axr(`SG_REG_CTRL, 34'h200);
    axr(32'h20, {2'b10, 32'h0});
    axw(32'h24, 32'h1, 2'b10);
    for (int i = 0; i < 4; i++) axr(16 + 4 * i, {2'b00, FP_WORDS[32 * i +: 32]});
    axw(32'h10, 32'hFFFFFFFF, 2'b00);
    axr(32'h10, {2'b00, FP_WORDS[31:0]});
    lag <= 4'($urandom_range(9, 2));
    axw(`SG_REG_CTRL, 32'h208, 2'b00);
    axw(32'h4, {29'h0, tgt}, 2'b00);
    for (int i = 0; i < 60 && indReq !== 1'b1; i++) @(negedge clk_sys);
    cmp("fadeLvl", 0, fadeLvl);
    cmp("curMem", keptMem, curMem);
    for (int i = 0; i < 60 && fadeLvl !== 8'h10; i++) @(negedge clk_sys);
    cmp("curMem", tgt, curMem);
    axr(32'h4, {31'h0, tgt});
    minFade = 8'hFF;
    axw(`SG_REG_CTRL, 32'h218, 2'b00);
    for (int i = 0; i < 60 && toneEn !== 1'b1; i++) @(negedge clk_sys);
    cmp("minFade", 0, minFade);
    axw(`SG_REG_CTRL, 32'h238, 2'b00);
    repeat (40) @(negedge clk_sys);
    cmp("fadeLvl", 0, fadeLvl);
    axw(`SG_REG_CTRL, 32'h218, 2'b00);
    repeat (40) @(negedge clk_sys);
    cmp("fadeLvl", 16, fadeLvl);
    axw(32'h8, 32'h1, 2'b00);
    repeat (3) @(negedge clk_sys);
    cmp("comCnt", 1, comCnt);
    setw(DIP, 8);
    cmp("audioEn", 0, audioEn);
    setw(MID, 8);
    cmp("audioEn", 0, audioEn);
    setw(OK, 8);
    cmp("audioEn", 1, audioEn);
    axw(`SG_REG_CTRL, 32'h219, 2'b00);
    setw(DIP, 8);
    setw(OK, 8);
    cmp("audioEn", 0, audioEn);
    setw(9'h009, 8);
    cmp("curMem", 0, curMem);
    setw(OK, 40);
    cmp("audioEn", 1, audioEn);
    axw(`SG_REG_CTRL, 32'h21A, 2'b00);
    setw(DIP, 3);
    setw(OK, 8);
    cmp("gainCut", 3, gainCut);
    setw(DIP, 3);
    setw(OK, 300);
    cmp("gainCut", 3, gainCut);
    setw(DIP, 3);
    setw(OK, 320);
    cmp("gainCut", 6, gainCut);
    setw(DIP, 3);
    setw(MID, 700);
    cmp("gainCut", 3, gainCut);
    setw(OK, 700);
    cmp("gainCut", 0, gainCut);
    setw(9'h016, 1000);
    cmp("avgStep", 1, gainCut inside {[5'h9 : 5'hB]});
    repeat (1000) @(negedge clk_sys);
    cmp("gainCut", 18, gainCut);
    cmp("audioEn", 0, audioEn);
    setw(9'h006, 300);
    cmp("gainCut", 18, gainCut);
    setw(OK, 10);
    cmp("audioEn", 1, audioEn);
    repeat (2000) @(negedge clk_sys);
    cmp("gainCut", 0, gainCut);
    axw(`SG_REG_CTRL, 32'h21C, 2'b00);
    lowCnt = 0;
    setw(9'h066, 3050);
    cmp("lowCnt", 2, lowCnt);
    @(posedge clk_sys);
    srst <= 1'b1;
    want <= 9'h126;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (80) @(negedge clk_sys);
    cmp("curMem", 0, curMem);
    cmp("audioEn", 1, audioEn);
    print_verdict();
  end
endmodule
`default_nettype wire
